// [core/xb_pkg.sv]
// shared constants, carriers and ecc helpers for the crossbar controller
`default_nettype none
package xb_pkg;
   localparam int XB_NBUS = 3;
   localparam int XB_IO = 2;
   localparam int XB_NMEM = 2;
   localparam int XB_NPORT = XB_NBUS + XB_NMEM;
   localparam int XB_NROUTE = 9;
   localparam int XB_AW = 33;
   localparam int XB_DW = 64;
   localparam int XB_EW = 8;
   localparam int XB_LINE_OFS = 5;
   localparam int XB_NBUF = 64;
   localparam int XB_BUFW = 6;
   localparam int XB_FIFO_DEPTH = 16;
   localparam int XB_FIL_IW = 3;
   localparam int XB_FILN = 1 << XB_FIL_IW;
   localparam int XB_TAGW = XB_AW - XB_LINE_OFS - XB_FIL_IW;
   localparam int XB_BUS_MHZ = 100;
   localparam int XB_BEAT_BYTES = XB_DW / 8;
   localparam int XB_PEAK_MBPS = XB_BUS_MHZ * XB_BEAT_BYTES;
   localparam logic [1:0] XB_ECC_DATA_MARK = 2'h3;

   typedef enum logic [1:0] {XB_LINE_SHARED = 2'h1, XB_LINE_OWNED = 2'h2} xb_line_e;

   typedef struct packed {
      logic write;
      logic [XB_AW-1:0] addr;
      logic [XB_DW-1:0] data;
   } xb_cmd_s;

   typedef struct packed {
      logic valid;
      xb_cmd_s cmd;
   } xb_req_s;

   typedef struct packed {
      xb_cmd_s cmd;
      logic [XB_EW-1:0] ecc;
   } xb_fent_s;

   typedef struct packed {
      logic valid;
      logic [1:0] src;
      xb_cmd_s cmd;
   } xb_mreq_s;

   typedef struct packed {
      logic valid;
      logic [1:0] src;
      logic [XB_DW-1:0] data;
   } xb_rsp_s;

   typedef struct packed {
      logic valid;
      logic [XB_DW-1:0] data;
   } xb_brsp_s;

   typedef struct packed {
      logic valid;
      logic inval;
      logic [XB_AW-1:0] addr;
   } xb_snoop_s;

   typedef struct packed {
      logic [XB_DW-1:0] data;
      logic fixed;
      logic bad;
   } xb_chk_s;

   // data bit i checks into {2'h3, i}: never weight one, so check-bit flips are told apart
   function automatic logic [XB_EW-1:0] xb_ecc_gen(input logic [XB_DW-1:0] d);
      logic [XB_EW-1:0] c;
      c = '0;
      for (int i = 0; i < XB_DW; i++)
         if (d[i])
            c = c ^ {XB_ECC_DATA_MARK, 6'(i)};
      return c;
   endfunction

   function automatic xb_chk_s xb_ecc_check(input logic [XB_DW-1:0] d,
                                            input logic [XB_EW-1:0] e);
      xb_chk_s r;
      logic [XB_EW-1:0] s;
      s = e ^ xb_ecc_gen(d);
      r.data = d;
      r.fixed = 1'b0;
      r.bad = 1'b0;
      if (s[XB_EW-1 -: 2] == XB_ECC_DATA_MARK)
      begin
         r.data[s[5:0]] = ~d[s[5:0]];
         r.fixed = 1'b1;
      end
      else if ($countones(s) == 1)
         r.fixed = 1'b1;
      else if (s != '0)
         r.bad = 1'b1;
      return r;
   endfunction
endpackage : xb_pkg
`default_nettype wire

// [core/xb_fifo.sv]
// parameterised synchronous fifo with registered ready
`default_nettype none
module xb_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire logic i_valid,
   input wire logic [W-1:0] i_data,
   output var logic o_ready,
   output wire logic o_valid,
   output wire logic [W-1:0] o_data,
   input wire logic i_ready
);
   // pointers wrap naturally, so DEPTH must be a power of two
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic [AW:0] cnt_next;
   logic push;
   logic pop;

   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;
   assign o_valid = (cnt_reg != '0);
   assign o_data = mem_reg[rd_reg];

   always_comb
      cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         o_ready <= 1'b0;
      end
      else
      begin
         if (push)
            wr_reg <= wr_reg + AW'(1);
         if (pop)
            rd_reg <= rd_reg + AW'(1);
         cnt_reg <= cnt_next;
         // ready looks at the next count, so a one-cycle lag never overfills
         o_ready <= i_enable && (cnt_next < (AW+1)'(DEPTH));
      end

   always_ff @(posedge i_sys_clk)
      if (push)
         mem_reg[wr_reg] <= i_data;

   fifo_ovf_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n) push |-> cnt_reg < (AW+1)'(DEPTH))
      else $error("fifo written while full");
endmodule // xb_fifo
`default_nettype wire

// [core/xb_linebuf.sv]
// cache line buffer store with registered read data
`default_nettype none
module xb_linebuf #(
   parameter int W = 72,
   parameter int N = 64
)
(
   input wire logic i_sys_clk,
   input wire logic i_we,
   input wire logic [$clog2(N)-1:0] i_waddr,
   input wire logic [W-1:0] i_wdata,
   input wire logic i_re,
   input wire logic [$clog2(N)-1:0] i_raddr,
   output var logic [W-1:0] o_rdata
);
   logic [W-1:0] mem_reg [N];

   always_ff @(posedge i_sys_clk)
      if (i_we)
         mem_reg[i_waddr] <= i_wdata;

   always_ff @(posedge i_sys_clk)
      if (i_re)
         o_rdata <= mem_reg[i_raddr];
endmodule // xb_linebuf
`default_nettype wire

// [core/xb_crossbar.sv]
// five-port crossbar controller: address/control unit and data buffer unit
`default_nettype none
// What this block does
// - five ports, all able to pass requests in the same cycle; read data moves from one memory port to one bus per cycle
// - read return path runs apart from the write request path
// - nine direct routes among processor buses, memories and i/o bus
// - addresses go through address/control logic, read return data through the buffer unit
// - address/control logic runs filters and tracks each buffer's owner
// - decode up to eight gigabytes of main memory
// - sixty-four line buffers, any buffer serves any read return
// - data carried with ecc, checked and corrected between ports
// - even lines go to memory port 0, odd lines to port 1
// - both processor buses reach both memory ports with equal access
// - one filter per processor bus records lines held by its caches
// - filter state decides if a snoop crosses to the other bus
// - i/o filter checks bridge buffers before going to memory
// - one eight-byte beat per port per cycle
// - processor and i/o buses are 64 bits wide
// - processor buses are linked only for a crossing transfer
module xb_crossbar
   import xb_pkg::*;
#(
   parameter int FIFO_DEPTH = XB_FIFO_DEPTH
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire xb_req_s [XB_NBUS-1:0] i_bus_req,
   output wire logic [XB_NBUS-1:0] o_bus_ready,
   output var xb_brsp_s [XB_NBUS-1:0] o_bus_rsp,
   output var xb_snoop_s [XB_NMEM-1:0][XB_NBUS-1:0] o_snoop,
   output var xb_mreq_s [XB_NMEM-1:0] o_mem_req,
   input wire logic [XB_NMEM-1:0] i_mem_ready,
   input wire xb_rsp_s [XB_NMEM-1:0] i_mem_rsp,
   output var logic [XB_NMEM-1:0] o_mem_rsp_ready,
   output var logic o_ecc_fixed,
   output var logic o_ecc_error
);
   logic init_reg;
   logic [XB_NBUS-1:0] f_valid;
   logic [XB_NBUS-1:0] f_pop;
   xb_fent_s [XB_NBUS-1:0] fout;
   logic [XB_NBUS-1:0] want [XB_NMEM];
   logic [XB_NMEM-1:0] slot_free;
   logic [XB_NMEM-1:0] gnt_any;
   logic [1:0] gnt_bus [XB_NMEM];
   logic [1:0] rr_reg [XB_NMEM];
   xb_fent_s gent [XB_NMEM];
   xb_chk_s gchk [XB_NMEM];
   logic [XB_FIL_IW-1:0] gidx [XB_NMEM];
   logic [XB_TAGW-1:0] gtag [XB_NMEM];
   logic [XB_NBUS-1:0] hit [XB_NMEM];
   logic [XB_NMEM-1:0] io_local;
   xb_snoop_s [XB_NBUS-1:0] snp_next [XB_NMEM];
   xb_mreq_s mreq_next [XB_NMEM];
   logic [XB_FILN-1:0] fil_v_reg [XB_NBUS];
   logic [XB_TAGW-1:0] fil_tag_reg [XB_NBUS][XB_FILN];
   xb_line_e fil_st_reg [XB_NBUS][XB_FILN];
   logic [XB_NMEM-1:0] rsp_take;
   xb_rsp_s rsp_in;
   logic [XB_NBUF-1:0] free_reg;
   logic [XB_BUFW-1:0] alloc;
   logic [1:0] buf_dest_reg [XB_NBUF];
   logic s1_v_reg;
   logic s2_v_reg;
   logic [XB_BUFW-1:0] s1_idx_reg;
   logic [XB_BUFW-1:0] s2_idx_reg;
   logic [XB_DW+XB_EW-1:0] buf_rdata;
   xb_chk_s rchk;
   logic fix_any;
   logic bad_any;

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         init_reg <= 1'b0;
      else
         init_reg <= 1'b1;

   // one input fifo per bus, so each bus streams a beat per cycle on its own
   for (genvar b = 0; b < XB_NBUS; b++)
   begin : g_in
      xb_fent_s push_ent;
      assign push_ent = '{cmd: i_bus_req[b].cmd, ecc: xb_ecc_gen(i_bus_req[b].cmd.data)};
      xb_fifo #(.W($bits(xb_fent_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
         .i_sys_clk(i_sys_clk),
         .i_rst_n(i_rst_n),
         .i_enable(init_reg),
         .i_valid(i_bus_req[b].valid),
         .i_data(push_ent),
         .o_ready(o_bus_ready[b]),
         .o_valid(f_valid[b]),
         .o_data(fout[b]),
         .i_ready(f_pop[b])
      );
   end

   // per memory lane round robin over the three bus fifos
   always_comb
   begin
      int idx;
      idx = 0;
      f_pop = '0;
      for (int m = 0; m < XB_NMEM; m++)
      begin
         slot_free[m] = !o_mem_req[m].valid || i_mem_ready[m];
         gnt_any[m] = 1'b0;
         gnt_bus[m] = rr_reg[m];
         for (int b = 0; b < XB_NBUS; b++)
            want[m][b] = f_valid[b] && (fout[b].cmd.addr[XB_LINE_OFS] == 1'(m));
         for (int k = XB_NBUS - 1; k >= 0; k--)
         begin
            idx = (int'(rr_reg[m]) + 1 + k) % XB_NBUS;
            if (want[m][idx])
            begin
               gnt_any[m] = slot_free[m];
               gnt_bus[m] = 2'(idx);
            end
         end
         if (gnt_any[m])
            f_pop[gnt_bus[m]] = 1'b1;
         gent[m] = fout[gnt_bus[m]];
         gchk[m] = xb_ecc_check(gent[m].cmd.data, gent[m].ecc);
         gidx[m] = gent[m].cmd.addr[XB_LINE_OFS +: XB_FIL_IW];
         gtag[m] = gent[m].cmd.addr[XB_AW-1 -: XB_TAGW];
      end
   end

   // filter lookup; the two lanes never touch the same entry since bit 5 is in the index
   always_comb
   begin
      for (int m = 0; m < XB_NMEM; m++)
      begin
         for (int f = 0; f < XB_NBUS; f++)
         begin
            hit[m][f] = fil_v_reg[f][gidx[m]] && (fil_tag_reg[f][gidx[m]] == gtag[m]);
            snp_next[m][f] = '0;
            if (gnt_any[m] && (2'(f) != gnt_bus[m]) && hit[m][f] &&
                (gent[m].cmd.write || fil_st_reg[f][gidx[m]] == XB_LINE_OWNED))
               snp_next[m][f] = '{valid: 1'b1, inval: gent[m].cmd.write,
                                  addr: gent[m].cmd.addr};
            else if (gnt_any[m] && (2'(f) == gnt_bus[m]) && fil_v_reg[f][gidx[m]] &&
                     !hit[m][f])
               // the filter must stay inclusive, so a displaced line is recalled
               snp_next[m][f] = '{valid: 1'b1, inval: 1'b1,
                                  addr: {fil_tag_reg[f][gidx[m]], gidx[m],
                                         XB_LINE_OFS'(0)}};
         end
         io_local[m] = gnt_any[m] && (gnt_bus[m] == 2'(XB_IO)) && !gent[m].cmd.write &&
                       hit[m][XB_IO];
         if (io_local[m])
            snp_next[m][XB_IO] = '{valid: 1'b1, inval: 1'b0, addr: gent[m].cmd.addr};
         mreq_next[m] = '{valid: gnt_any[m] && !io_local[m] &&
                                 !(gent[m].cmd.write && gchk[m].bad),
                          src: gnt_bus[m],
                          cmd: '{write: gent[m].cmd.write, addr: gent[m].cmd.addr,
                                 data: gchk[m].data}};
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         o_mem_req <= '0;
      else
         for (int m = 0; m < XB_NMEM; m++)
            if (slot_free[m])
               o_mem_req[m] <= mreq_next[m];

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         rr_reg <= '{default: '0};
      else
         for (int m = 0; m < XB_NMEM; m++)
            if (gnt_any[m])
               rr_reg[m] <= gnt_bus[m];

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         o_snoop <= '0;
      else
         for (int m = 0; m < XB_NMEM; m++)
            o_snoop[m] <= snp_next[m];

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         fil_v_reg <= '{default: '0};
      else
         for (int m = 0; m < XB_NMEM; m++)
            for (int f = 0; f < XB_NBUS; f++)
               if (gnt_any[m] && (2'(f) == gnt_bus[m]))
                  fil_v_reg[f][gidx[m]] <= 1'b1;
               else if (gnt_any[m] && hit[m][f] && gent[m].cmd.write)
                  fil_v_reg[f][gidx[m]] <= 1'b0;

   // tag and state are qualified by the valid bits, so they need no reset
   always_ff @(posedge i_sys_clk)
      for (int m = 0; m < XB_NMEM; m++)
         for (int f = 0; f < XB_NBUS; f++)
            if (gnt_any[m] && (2'(f) == gnt_bus[m]))
            begin
               fil_tag_reg[f][gidx[m]] <= gtag[m];
               fil_st_reg[f][gidx[m]] <= gent[m].cmd.write ? XB_LINE_OWNED : XB_LINE_SHARED;
            end
            else if (gnt_any[m] && hit[m][f] && fil_st_reg[f][gidx[m]] == XB_LINE_OWNED)
               fil_st_reg[f][gidx[m]] <= XB_LINE_SHARED;

   // read return path, independent of the request lanes
   always_comb
   begin
      rsp_take = '0;
      fix_any = 1'b0;
      bad_any = 1'b0;
      for (int m = 0; m < XB_NMEM; m++)
      begin
         rsp_take[m] = i_mem_rsp[m].valid && o_mem_rsp_ready[m];
         fix_any = fix_any || (gnt_any[m] && gchk[m].fixed);
         bad_any = bad_any || (gnt_any[m] && gent[m].cmd.write && gchk[m].bad);
      end
      rsp_in = i_mem_rsp[o_mem_rsp_ready[1]];
      alloc = xb_first_free(free_reg);
      rchk = xb_ecc_check(buf_rdata[XB_DW+XB_EW-1 -: XB_DW], buf_rdata[XB_EW-1:0]);
   end

   function automatic logic [XB_BUFW-1:0] xb_first_free(input logic [XB_NBUF-1:0] fr);
      logic [XB_BUFW-1:0] k;
      k = '0;
      for (int i = XB_NBUF - 1; i >= 0; i--)
         if (fr[i])
            k = XB_BUFW'(i);
      return k;
   endfunction

   // one memory port is offered ready at a time; the token moves when the other waits
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
         o_mem_rsp_ready <= '0;
      else if (!init_reg)
         o_mem_rsp_ready <= '0;
      else if (i_mem_rsp[!o_mem_rsp_ready[1]].valid)
         o_mem_rsp_ready <= o_mem_rsp_ready[1] ? 2'h1 : 2'h2;
      else
         o_mem_rsp_ready <= o_mem_rsp_ready[1] ? 2'h2 : 2'h1;

   // a buffer lives three cycles, so the pool cannot run dry
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         free_reg <= '1;
         s1_v_reg <= 1'b0;
         s2_v_reg <= 1'b0;
         s1_idx_reg <= '0;
         s2_idx_reg <= '0;
      end
      else
      begin
         s1_v_reg <= |rsp_take;
         s1_idx_reg <= alloc;
         s2_v_reg <= s1_v_reg;
         s2_idx_reg <= s1_idx_reg;
         if (|rsp_take)
            free_reg[alloc] <= 1'b0;
         if (s2_v_reg)
            free_reg[s2_idx_reg] <= 1'b1;
      end

   always_ff @(posedge i_sys_clk)
      if (|rsp_take)
         buf_dest_reg[alloc] <= rsp_in.src;

   xb_linebuf #(.W(XB_DW + XB_EW), .N(XB_NBUF)) u_buf (
      .i_sys_clk(i_sys_clk),
      .i_we(|rsp_take),
      .i_waddr(alloc),
      .i_wdata({rsp_in.data, xb_ecc_gen(rsp_in.data)}),
      .i_re(s1_v_reg),
      .i_raddr(s1_idx_reg),
      .o_rdata(buf_rdata)
   );

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n)
      begin
         o_bus_rsp <= '0;
         o_ecc_fixed <= 1'b0;
         o_ecc_error <= 1'b0;
      end
      else
      begin
         for (int b = 0; b < XB_NBUS; b++)
            o_bus_rsp[b] <= '{valid: s2_v_reg && (buf_dest_reg[s2_idx_reg] == 2'(b)),
                              data: rchk.data};
         o_ecc_fixed <= fix_any || (s2_v_reg && rchk.fixed);
         o_ecc_error <= bad_any || (s2_v_reg && rchk.bad);
      end

   for (genvar m = 0; m < XB_NMEM; m++)
   begin : g_chk
      line_steer_a: assert property (
         @(posedge i_sys_clk) disable iff (!i_rst_n)
         o_mem_req[m].valid |-> o_mem_req[m].cmd.addr[XB_LINE_OFS] == 1'(m))
         else $error("request sent to the wrong memory lane");
      req_hold_a: assert property (
         @(posedge i_sys_clk) disable iff (!i_rst_n)
         o_mem_req[m].valid && !i_mem_ready[m] |=> $stable(o_mem_req[m]))
         else $error("stalled memory request changed");
      bad_drop_a: assert property (
         @(posedge i_sys_clk) disable iff (!i_rst_n)
         gnt_any[m] && gent[m].cmd.write && gchk[m].bad |=> !o_mem_req[m].valid)
         else $error("uncorrectable write reached memory");
      io_local_a: assert property (
         @(posedge i_sys_clk) disable iff (!i_rst_n)
         io_local[m] |=> !o_mem_req[m].valid && o_snoop[m][XB_IO].valid)
         else $error("i/o read held by a bridge went to memory");
      rr_turn_a: assert property (
         @(posedge i_sys_clk) disable iff (!i_rst_n)
         gnt_any[m] ##1 gnt_any[m] && want[m][$past(gnt_bus[m])] && $countones(want[m]) > 1
         |-> gnt_bus[m] != $past(gnt_bus[m]))
         else $error("same bus granted twice while another waits");
   end

   buf_alloc_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      |rsp_take |-> free_reg[alloc] ##1 !free_reg[$past(alloc)])
      else $error("line buffer allocated while busy");
   rsp_path_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      |rsp_take |=> s1_v_reg ##1 s2_v_reg ##1
      (o_bus_rsp[0].valid || o_bus_rsp[1].valid || o_bus_rsp[2].valid))
      else $error("read data not delivered three cycles after acceptance");
   reset_clean_a: assert property (
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      !init_reg |-> free_reg == '1 && fil_v_reg[0] == '0 && fil_v_reg[1] == '0 &&
      fil_v_reg[2] == '0 && o_bus_ready == '0)
      else $error("state not clean before requests are accepted");
endmodule // xb_crossbar
`default_nettype wire

// [dv/xb_mem_model.sv]
// behavioural two-lane memory standing behind the crossbar's memory ports
`default_nettype none
module xb_mem_model
   import xb_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_stall,
   input wire xb_mreq_s [XB_NMEM-1:0] i_req,
   output var logic [XB_NMEM-1:0] o_ready,
   output var xb_rsp_s [XB_NMEM-1:0] o_rsp,
   input wire logic [XB_NMEM-1:0] i_rsp_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   // full 64-bit beat stored per address
   logic [XB_DW-1:0] mem [logic [XB_AW-1:0]];
   xb_rsp_s q [XB_NMEM][$];
   logic [15:0] lf = 16'hace1;
   initial
   begin
      o_ready = '0;
      o_rsp = '0;
   end
   always @(posedge i_sys_clk)
   begin
      lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      for (int m = 0; m < XB_NMEM; m++)
      begin
         if (i_req[m].valid && o_ready[m])
         begin
            if (i_req[m].cmd.write)
               mem[i_req[m].cmd.addr] = i_req[m].cmd.data;
            else
               q[m].push_back({1'b1, i_req[m].src, mem[i_req[m].cmd.addr]});
         end
         if (o_rsp[m].valid && i_rsp_ready[m])
            void'(q[m].pop_front());
         // idle lines flip so a stale beat is never mistaken for data
         if (q[m].size() > 0)
            o_rsp[m] <= q[m][0];
         else
            o_rsp[m] <= {1'b0, 2'h0, ~o_rsp[m].data};
         o_ready[m] <= !i_stall && lf[m];
      end
   end
endmodule // xb_mem_model
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for the crossbar controller
`default_nettype none
module tb_top
   import xb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DEPTH = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic stall = 1'b0;
   xb_req_s [XB_NBUS-1:0] bus_req = '0;
   logic [XB_NBUS-1:0] bus_ready;
   xb_brsp_s [XB_NBUS-1:0] bus_rsp;
   xb_snoop_s [XB_NMEM-1:0][XB_NBUS-1:0] snoop;
   xb_mreq_s [XB_NMEM-1:0] mem_req;
   logic [XB_NMEM-1:0] mem_ready;
   logic [XB_NMEM-1:0] mem_rsp_ready;
   xb_rsp_s [XB_NMEM-1:0] mem_rsp;
   logic ecc_fixed;
   logic ecc_error;
   int fail_count = 0;
   int n_tests = 0;
   int snp_cnt [XB_NBUS];
   int snp_inv [XB_NBUS];
   logic snp_on = 1'b0;
   logic [XB_DW-1:0] expq [XB_NBUS][$];
   logic [XB_DW-1:0] shadow [logic [XB_AW-1:0]];
   logic [XB_AW-1:0] wlist [XB_NMEM][$];
   logic [31:0] seed = 32'h0000_9a4a;

   xb_crossbar #(.FIFO_DEPTH(DEPTH)) uut (.i_sys_clk(clk), .i_rst_n(rst_n),
      .i_bus_req(bus_req), .o_bus_ready(bus_ready), .o_bus_rsp(bus_rsp), .o_snoop(snoop),
      .o_mem_req(mem_req), .i_mem_ready(mem_ready), .i_mem_rsp(mem_rsp),
      .o_mem_rsp_ready(mem_rsp_ready), .o_ecc_fixed(ecc_fixed), .o_ecc_error(ecc_error));
   xb_mem_model mem (.i_sys_clk(clk), .i_stall(stall), .i_req(mem_req), .o_ready(mem_ready),
      .o_rsp(mem_rsp), .i_rsp_ready(mem_rsp_ready));

   initial
   begin
      forever #50 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [XB_AW-1:0] mk(input int b, input int i);
      logic [31:0] r;
      r = rnd();
      return XB_AW'({r[18:0], 2'(b), 4'(i), r[31], 5'h00});
   endfunction

   task automatic cmp(input string w, input logic [XB_DW-1:0] e, input logic [XB_DW-1:0] g);
      n_tests++;
      if (e !== g)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic cmpf(input string w, input logic e, input logic g);
      cmp(w, 64'(e), 64'(g));
   endtask

   task automatic results();
      if (fail_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // request and its data stay put until ready is seen high at an edge
   task automatic send(input int b, input logic w, input logic [XB_AW-1:0] a,
                       input logic [XB_DW-1:0] d, input int lim, output logic ok);
      ok = 1'b0;
      bus_req[b] <= {1'b1, w, a, d};
      for (int k = 0; k < lim && !ok; k++)
      begin
         @(posedge clk);
         ok = (bus_ready[b] === 1'b1);
      end
      if (ok && w)
      begin
         shadow[a] = d;
         wlist[a[5]].push_back(a);
      end
      else if (ok)
         expq[b].push_back(shadow[a]);
      if (!ok && lim > 1)
      begin
         fail_count++;
         results();
      end
   endtask

   task automatic wrs(input int b, input int n, input int o);
      logic ok;
      for (int i = 0; i < n; i++)
         send(b, 1'b1, mk(b, i + o), {rnd(), rnd()}, 100, ok);
      bus_req[b].valid <= 1'b0;
   endtask

   task automatic rds(input int b, input int l);
      logic [XB_AW-1:0] q [$];
      logic ok;
      q = wlist[l];
      foreach (q[j])
         send(b, 1'b0, q[j], {rnd(), rnd()}, 100, ok);
      bus_req[b].valid <= 1'b0;
   endtask

   task automatic settle();
      int idle;
      idle = 0;
      for (int k = 0; k < 1000 && idle < 8; k++)
      begin
         @(posedge clk);
         if (mem_req[0].valid | mem_req[1].valid |
             (expq[0].size() + expq[1].size() + expq[2].size() > 0))
            idle = 0;
         else
            idle++;
      end
      if (idle < 8)
      begin
         fail_count++;
         results();
      end
   endtask

   task automatic one(input int b, input logic w, input logic [XB_AW-1:0] a);
      logic ok;
      send(b, w, a, {rnd(), rnd()}, 100, ok);
      bus_req[b].valid <= 1'b0;
      settle();
   endtask

   task automatic do_reset();
      int k;
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      cmpf("ready in reset", 1'b0, |bus_ready);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      cmpf("ready at init", 1'b0, |bus_ready);
      for (k = 0; k < 20 && bus_ready !== 3'h7; k++)
         @(posedge clk);
      cmpf("ready after init", 1'b1, bus_ready === 3'h7);
      if (bus_ready !== 3'h7)
         results();
   endtask

   always @(posedge clk)
   begin
      for (int b = 0; b < XB_NBUS; b++)
      begin
         if (bus_rsp[b].valid === 1'b1 && expq[b].size() > 0)
            cmp("read data", expq[b].pop_front(), bus_rsp[b].data);
         else if (bus_rsp[b].valid === 1'b1)
            cmpf("stray read", 1'b0, 1'b1);
         for (int m = 0; m < XB_NMEM; m++)
            if (snp_on && snoop[m][b].valid === 1'b1)
            begin
               snp_cnt[b]++;
               snp_inv[b] += int'(snoop[m][b].inval === 1'b1);
            end
      end
      for (int m = 0; m < XB_NMEM; m++)
         if (mem_req[m].valid === 1'b1)
            cmpf("lane select", 1'(m), mem_req[m].cmd.addr[5]);
      cmpf("ecc flags", 1'b0, ecc_fixed | ecc_error);
   end

   initial
   begin
      logic ok;
      logic [XB_DW-1:0] d;
      logic [XB_AW-1:0] a;
      int n;
      do_reset();
      stall <= 1'b1;
      n = 0;
      ok = 1'b1;
      while (ok && n < 12)
      begin
         d = {rnd(), rnd()};
         a = XB_AW'(n * 64);
         send(0, 1'b1, a, d, 1, ok);
         n = n + int'(ok);
      end
      cmpf("fifo refusal", 1'b1, n >= DEPTH && n <= DEPTH + 2);
      stall <= 1'b0;
      send(0, 1'b1, a, d, 100, ok);
      bus_req[0].valid <= 1'b0;
      settle();
      fork
         wrs(0, 12, 0);
         wrs(1, 12, 0);
         wrs(2, 12, 0);
      join
      settle();
      // reads on both processor buses while the i/o bus keeps writing
      for (int l = 0; l < 2; l++)
      begin
         fork
            rds(0, l);
            rds(1, 1 - l);
            wrs(2, 2, 12 + 2 * l);
         join
         settle();
      end
      do_reset();
      snp_cnt = '{0, 0, 0};
      snp_inv = '{0, 0, 0};
      snp_on <= 1'b1;
      one(0, 1'b1, 33'h0_0000_0020);
      one(1, 1'b0, 33'h0_0000_0020);
      one(1, 1'b1, 33'h0_0000_0020);
      one(1, 1'b1, 33'h1_0000_0020);
      one(2, 1'b1, 33'h0_0000_0040);
      // a bridge-held line is answered by a snoop, so no read data may come back
      send(2, 1'b0, 33'h0_0000_0040, {rnd(), rnd()}, 100, ok);
      bus_req[2].valid <= 1'b0;
      void'(expq[2].pop_front());
      settle();
      // a line no bridge holds goes to memory and returns on the i/o bus
      one(2, 1'b0, 33'h0_0000_0020);
      cmp("snoops bus0", 64'(2), 64'(snp_cnt[0]));
      cmp("invals bus0", 64'(1), 64'(snp_inv[0]));
      cmp("snoops bus1", 64'(1), 64'(snp_cnt[1]));
      cmp("invals bus1", 64'(1), 64'(snp_inv[1]));
      cmp("snoops bus2", 64'(1), 64'(snp_cnt[2]));
      cmp("invals bus2", 64'(0), 64'(snp_inv[2]));
      results();
   end
endmodule // tb_top
`default_nettype wire
